// file: core/ssp_pkg.sv
/*
 Shared constants for the serial program port: program word field layout,
 divisor codes and reset values.
 Assumes nothing of its surroundings.
*/
package ssp_pkg;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned DIV_W      = 6;
  // field positions, first shifted field at the top
  localparam int unsigned PRE_HI     = 31;
  localparam int unsigned PRE_LO     = 28;
  localparam int unsigned QP_HI      = 27;
  localparam int unsigned QP_LO      = 23;
  localparam int unsigned QPM_HI     = 22;
  localparam int unsigned QPM_LO     = 18;
  localparam int unsigned DSEL_HI    = 17;
  localparam int unsigned DSEL_LO    = 14;
  localparam int unsigned MFG_HI     = 13;
  localparam int unsigned MFG_LO     = 11;
  localparam int unsigned PDIV_HI    = 10;
  localparam int unsigned PDIV_LO    = 6;
  localparam int unsigned NSEL_HI    = 5;
  localparam int unsigned NSEL_LO    = 3;
  localparam int unsigned MSEL_HI    = 2;
  localparam int unsigned MSEL_LO    = 0;
  // post-divider code bands
  localparam logic [4:0] PD_CODE_ONE   = 5'h00;
  localparam logic [4:0] PD_CODE_THREE = 5'h01;
  localparam logic [4:0] PD_BAND2      = 5'h10;
  localparam logic [4:0] PD_BAND4      = 5'h18;
  localparam logic [5:0] PD_DIV_ONE    = 6'h01;
  localparam logic [5:0] PD_DIV_THREE  = 6'h03;
  localparam logic [5:0] PD_BASE2      = 6'h10;
  localparam logic [5:0] PD_BASE4      = 6'h20;
  // wrapper divisors
  localparam logic [5:0] WD_14 = 6'h0e;
  localparam logic [5:0] WD_15 = 6'h0f;
  localparam logic [5:0] WD_16 = 6'h10;
  localparam logic [5:0] WD_17 = 6'h11;
  localparam logic [5:0] WD_18 = 6'h12;
  localparam logic [5:0] WD_31 = 6'h1f;
  localparam logic [5:0] WD_32 = 6'h20;
  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [5:0]  CNT_RST  = 6'h00;
  localparam logic [5:0]  DIV_ONE  = 6'h01;
endpackage

// file: core/ssp_sync2.sv
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input is quasi-static relative to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_sync2
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // level
  input  wire logic asyncIn,
  output var  logic syncOut
);
  logic stage1Reg;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1Reg <= 1'b0;
      syncOut   <= 1'b0;
    end
    else
    begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end
endmodule
`default_nettype wire

// file: core/ssp_program_port.sv
/*
 Serial program port of a fractional-N synthesizer: shifts a 32-bit word,
 applies it on select fall, decodes wrapper and post-divider fields,
 divides the 20 MHz stand-in wrapper clock and reports lock.
 Assumes pins and analog lock flags are asynchronous to ref_clk.
*/
// Operation
// - numerator select decodes to 16,16,18,17,31,14,32,15
// - post-divider code decodes to 1,3, binary, steps of 2, steps of 4
// - output clock is the wrapper clock divided by the post-divider ratio; at ratio 1 it stays high
// - only rising edges are placed; duty cycle is not kept at half
// - one data bit is captured per serial clock rising edge
// - select low: serial data and clock are ignored, nothing shifts
// - select high: each captured bit shifts into the program register
// - select falling edge starts acquisition with the last shifted word
// - each field goes most significant bit first
// - field order: preamble, high gate, low gate, divide, maker, post, num, den
// - denominator select decodes with the numerator mapping
// - lock output high only while both loops are declared locked
`timescale 1ns/10ps
`default_nettype none
module ssp_program_port
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // serial pins
  input  wire logic                    serialProgClock,
  input  wire logic                    serialProgDataIn,
  input  wire logic                    serialProgSelect,
  // loop lock flags
  input  wire logic                    fracPllLocked,
  input  wire logic                    wrapPllLocked,
  // applied program
  output var  logic [ssp_pkg::WORD_W-1:0] programWord,
  output var  logic [4:0]              highCountGatingValue,
  output var  logic [4:0]              lowCountGatingValue,
  output var  logic [3:0]              divideSelect,
  output var  logic [ssp_pkg::DIV_W-1:0] numeratorDivisor,
  output var  logic [ssp_pkg::DIV_W-1:0] denominatorDivisor,
  output var  logic [ssp_pkg::DIV_W-1:0] postDivisor,
  // status and clock
  output var  logic                    acquireStart,
  output var  logic                    lockOut,
  output var  logic                    diffClockOutP,
  output var  logic                    diffClockOutN
);
  import ssp_pkg::*;

  logic sckSync, sdiSync, selSync, fracSync, wrapSync;
  logic sckPrevReg, selPrevReg;
  logic [WORD_W-1:0] shiftReg, shift_next;
  logic [DIV_W-1:0]  cntReg, cnt_next;

  // pins and lock flags are asynchronous: two flops each
  ssp_sync2 uSck (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(serialProgClock),
                  .syncOut(sckSync));
  ssp_sync2 uSdi (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(serialProgDataIn),
                  .syncOut(sdiSync));
  ssp_sync2 uSel (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(serialProgSelect),
                  .syncOut(selSync));
  ssp_sync2 uFrl (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(fracPllLocked),
                  .syncOut(fracSync));
  ssp_sync2 uWrl (.ref_clk(ref_clk), .reset_n(reset_n), .asyncIn(wrapPllLocked),
                  .syncOut(wrapSync));

  // wrapper divisor decode, shared by numerator and denominator
  function automatic logic [DIV_W-1:0] wrapDecode(input logic [2:0] code);
    logic [DIV_W-1:0] d;
    d = WD_16;
    unique case (code)
      3'h0, 3'h1: d = WD_16;
      3'h2:       d = WD_18;
      3'h3:       d = WD_17;
      3'h4:       d = WD_31;
      3'h5:       d = WD_14;
      3'h6:       d = WD_32;
      3'h7:       d = WD_15;
    endcase
    return d;
  endfunction

  // post divider decode; offset within a band is the low three code bits
  function automatic logic [DIV_W-1:0] postDecode(input logic [4:0] code);
    logic [DIV_W-1:0] d;
    d = {1'b0, code};
    if (code == PD_CODE_ONE)
      d = PD_DIV_ONE;
    else if (code == PD_CODE_THREE)
      d = PD_DIV_THREE;
    else if (code >= PD_BAND4)
      d = PD_BASE4 + {1'b0, code[2:0], 2'b00};
    else if (code >= PD_BAND2)
      d = PD_BASE2 + {2'b00, code[2:0], 1'b0};
    return d;
  endfunction

  // edge detection on synchronised pins
  wire sckRise = sckSync & ~sckPrevReg;
  wire selFall = ~selSync & selPrevReg;
  wire doShift = sckRise & selSync;
  assign shift_next = doShift ? {shiftReg[WORD_W-2:0], sdiSync} : shiftReg;

  // applied word decode
  wire [2:0] nSelNew = shiftReg[NSEL_HI:NSEL_LO];
  wire [2:0] mSelNew = shiftReg[MSEL_HI:MSEL_LO];
  wire [4:0] pSelNew = shiftReg[PDIV_HI:PDIV_LO];

  // post divider: one high cycle per period
  wire cntWrap = (cntReg >= postDivisor - DIV_ONE);
  assign cnt_next = cntWrap ? CNT_RST : cntReg + DIV_ONE;

  // shift register and edge history
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sckPrevReg <= 1'b0;
      selPrevReg <= 1'b0;
      shiftReg   <= WORD_RST;
    end
    else
    begin
      sckPrevReg <= sckSync;
      selPrevReg <= selSync;
      shiftReg   <= shift_next;
    end
  end

  // program applied on select fall
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      programWord          <= WORD_RST;
      highCountGatingValue <= WORD_RST[4:0];
      lowCountGatingValue  <= WORD_RST[4:0];
      divideSelect         <= WORD_RST[3:0];
      numeratorDivisor     <= WD_16;
      denominatorDivisor   <= WD_16;
      postDivisor          <= DIV_ONE;
      acquireStart         <= 1'b0;
    end
    else
    begin
      acquireStart <= selFall;
      if (selFall)
      begin
        programWord          <= shiftReg;
        highCountGatingValue <= shiftReg[QP_HI:QP_LO];
        lowCountGatingValue  <= shiftReg[QPM_HI:QPM_LO];
        divideSelect         <= shiftReg[DSEL_HI:DSEL_LO];
        numeratorDivisor     <= wrapDecode(nSelNew);
        denominatorDivisor   <= wrapDecode(mSelNew);
        postDivisor          <= postDecode(pSelNew);
      end
    end
  end

  // divided clock and lock; lock stays low while a program loads
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cntReg        <= CNT_RST;
      diffClockOutP <= 1'b0;
      diffClockOutN <= 1'b1;
      lockOut       <= 1'b0;
    end
    else
    begin
      cntReg        <= selFall ? CNT_RST : cnt_next;
      diffClockOutP <= cntWrap;
      diffClockOutN <= ~cntWrap;
      lockOut       <= fracSync & wrapSync & ~selFall & ~selSync;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // shifting
  a_no_shift_idle: assert property (!selSync |=> shiftReg == $past(shiftReg))
    else $error("shift register moved while select low");
  a_shift_bit_in: assert property (doShift |=> shiftReg[0] == $past(sdiSync))
    else $error("captured bit not shifted in");
  a_shift_msb_out: assert property (doShift
    |=> shiftReg[WORD_W-1:1] == $past(shiftReg[WORD_W-2:0]))
    else $error("shift did not move word up by one");

  // applying a program
  a_acq_on_fall: assert property (selFall
    |=> acquireStart && programWord == $past(shiftReg))
    else $error("select fall did not apply word");
  a_acq_one_cycle: assert property (acquireStart |=> !acquireStart)
    else $error("acquisition start longer than one cycle");
  a_word_held: assert property (!selFall |=> programWord == $past(programWord))
    else $error("program word changed without select fall");
  a_num_map: assert property (selFall && nSelNew == 3'h4 |=> numeratorDivisor == WD_31)
    else $error("numerator code 100 not 31");
  a_num_top: assert property (selFall && nSelNew == 3'h6 |=> numeratorDivisor == WD_32)
    else $error("numerator code 110 not 32");
  a_den_map: assert property (selFall && mSelNew == 3'h5 |=> denominatorDivisor == WD_14)
    else $error("denominator code 101 not 14");
  a_post_top: assert property (selFall && pSelNew == 5'h1f |=> postDivisor == 6'h3c)
    else $error("post code 11111 not 60");
  a_post_three: assert property (selFall && pSelNew == 5'h01 |=> postDivisor == 6'h03)
    else $error("post code 00001 not 3");
  a_post_binary: assert property (selFall && pSelNew == 5'h0b |=> postDivisor == 6'h0b)
    else $error("post code 01011 not 11");
  a_post_band2: assert property (selFall && pSelNew == 5'h11 |=> postDivisor == WD_18)
    else $error("post code 10001 not 18");
  a_post_band4: assert property (selFall && pSelNew == 5'h18 |=> postDivisor == WD_32)
    else $error("post code 11000 not 32");

  // lock and divided clock
  a_lock_both: assert property (lockOut |-> $past(fracSync) && $past(wrapSync))
    else $error("lock without both loops locked");
  a_diff_pair: assert property (diffClockOutN == !diffClockOutP)
    else $error("output pair not complementary");
  a_out_period: assert property (postDivisor == 6'h03 && !selFall && $rose(diffClockOutP)
    ##1 !selFall
    |-> !diffClockOutP ##1 !diffClockOutP ##1 diffClockOutP)
    else $error("output period not equal to divisor");
endmodule
`default_nettype wire

// file: bench/ssp_host_model.sv
/*
 Host model that drives the three serial program pins.
 Assumes ref_clk paces every pin change.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_host_model
(
  // clock
  input  wire logic ref_clk,
  // serial pins
  output var  logic serialProgClock,
  output var  logic serialProgDataIn,
  output var  logic serialProgSelect
);
  initial
  begin
    serialProgClock = 1'b0;
    serialProgDataIn = 1'b0;
    serialProgSelect = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // 4-cycle phases leave the 3-cycle margins
  task automatic send_word(input logic [31:0] w);
    tick(1);
    serialProgSelect <= 1'b1;
    tick(4);
    for (int i = 31; i >= 0; i--)
    begin
      serialProgDataIn <= w[i];
      serialProgClock <= 1'b0;
      tick(4);
      serialProgClock <= 1'b1;
      tick(4);
    end
    serialProgClock <= 1'b0;
    serialProgDataIn <= ~w[0];
    tick(4);
    serialProgSelect <= 1'b0;
    tick(1);
  endtask

  task automatic set_select(input logic v);
    tick(1);
    serialProgSelect <= v;
  endtask

  // clocks while deselected
  task automatic stray_clocks(input int n, input logic [31:0] pat);
    tick(1);
    for (int i = 0; i < n; i++)
    begin
      serialProgDataIn <= pat[i];
      serialProgClock <= 1'b1;
      tick(4);
      serialProgClock <= 1'b0;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_synth_serial_program_port.sv
/*
 Self-checking bench for the program port, random and corner words.
 Assumes the package and design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_synth_serial_program_port;
  import ssp_pkg::*;
  logic                ref_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                fracPllLocked = 1'b0;
  logic                wrapPllLocked = 1'b0;
  logic                serialProgClock, serialProgDataIn, serialProgSelect;
  logic [WORD_W-1:0]   programWord, w, lastWord;
  logic [4:0]          highCountGatingValue, lowCountGatingValue;
  logic [3:0]          divideSelect;
  logic [DIV_W-1:0]    numeratorDivisor, denominatorDivisor, postDivisor;
  logic                acquireStart, lockOut, diffClockOutP, diffClockOutN;
  int                  nMismatch = 0;
  int                  checks = 0;
  int                  seed = 38871;

  ssp_host_model u_ssp_host_model (.ref_clk, .serialProgClock, .serialProgDataIn,
    .serialProgSelect);
  ssp_program_port u_ssp_program_port (.ref_clk, .reset_n, .serialProgClock,
    .serialProgDataIn, .serialProgSelect, .fracPllLocked, .wrapPllLocked, .programWord,
    .highCountGatingValue, .lowCountGatingValue, .divideSelect, .numeratorDivisor,
    .denominatorDivisor, .postDivisor, .acquireStart, .lockOut, .diffClockOutP,
    .diffClockOutN);

  initial
    forever #25 ref_clk = ~ref_clk;

  function automatic logic [5:0] wdiv(input logic [2:0] c);
    case (c)
      3'h2: return 6'h12;
      3'h3: return 6'h11;
      3'h4: return 6'h1f;
      3'h5: return 6'h0e;
      3'h6: return 6'h20;
      3'h7: return 6'h0f;
      default: return 6'h10;
    endcase
  endfunction

  function automatic logic [5:0] pdiv(input logic [4:0] c);
    if (c == 5'h00) return 6'h01;
    if (c == 5'h01) return 6'h03;
    if (c < 5'h10) return {1'b0, c};
    if (c < 5'h18) return 6'h10 + 6'(2 * (c - 5'h10));
    return 6'h20 + 6'(4 * (c - 5'h18));
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d, checks %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_start;
    int k;
    k = 0;
    do
    begin
      tick(1);
      k++;
    end
    while (acquireStart !== 1'b1 && k < 20);
    check(acquireStart, 1'b1);
  endtask

  // cycles from one rising edge of the divided clock to the next
  task automatic period(input logic [5:0] d);
    int k;
    k = 0;
    while (diffClockOutP !== 1'b1 && k < 70)
    begin
      tick(1);
      k++;
    end
    check(diffClockOutN, !diffClockOutP);
    tick(1);
    k = 1;
    while (diffClockOutP !== 1'b1 && k < 70)
    begin
      tick(1);
      k++;
    end
    check(32'(k), {26'h0, d});
  endtask

  task automatic run_word(input logic [31:0] wd);
    u_ssp_host_model.send_word(wd);
    wait_start;
    tick(1);
    check(programWord, wd);
    check(highCountGatingValue, wd[27:23]);
    check(lowCountGatingValue, wd[22:18]);
    check(divideSelect, wd[17:14]);
    check(numeratorDivisor, wdiv(wd[5:3]));
    check(denominatorDivisor, wdiv(wd[2:0]));
    check(postDivisor, pdiv(wd[10:6]));
    if (pdiv(wd[10:6]) > 6'h01)
      period(pdiv(wd[10:6]));
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(1);
    check(programWord, 32'h0000_0000);
    check(numeratorDivisor, 6'h10);
    check(postDivisor, 6'h01);
    @(posedge ref_clk);
    fracPllLocked <= 1'b1;
    run_word(32'h01e1c02d);
    check(lockOut, 1'b0);
    @(posedge ref_clk);
    wrapPllLocked <= 1'b1;
    tick(6);
    check(lockOut, 1'b1);
    for (int i = 0; i < 32; i++)
    begin
      w = $random(seed);
      w[31:28] = 4'h0;
      w[13:11] = 3'h0;
      w[10:6] = i[4:0];
      w[5:3] = i[2:0];
      w[2:0] = i[2:0] ^ (i[2] ? 3'h2 : 3'h1);
      run_word(w);
    end
    lastWord = w;
    u_ssp_host_model.stray_clocks(12, $random(seed));
    u_ssp_host_model.set_select(1'b1);
    tick(6);
    check(lockOut, 1'b0);
    u_ssp_host_model.set_select(1'b0);
    wait_start;
    tick(1);
    check(programWord, lastWord);
    report_and_stop;
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    nMismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
